// file: rtl/spc_defines.vh
/*
 serial port configuration bank: register offsets, field positions,
 reset values and neutral identity defaults.
 assumes an 8-bit register port with 12-bit addresses from the serial engine.
*/
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// register offsets
`define SPC_ADDR_CFG_A 12'h000
`define SPC_ADDR_CFG_B 12'h001
`define SPC_ADDR_CLASS 12'h003
`define SPC_ADDR_SER_LO 12'h004
`define SPC_ADDR_SER_HI 12'h005
`define SPC_ADDR_SIREV 12'h006
`define SPC_ADDR_IFVER 12'h00b
`define SPC_ADDR_VEND_LO 12'h00c
`define SPC_ADDR_VEND_HI 12'h00d
`define SPC_ADDR_COMMIT 12'h00f

// config a fields, each with its mirror
`define SPC_A_RESET 0
`define SPC_A_RESET_M 7
`define SPC_A_MSBF 1
`define SPC_A_MSBF_M 6
`define SPC_A_ASC 2
`define SPC_A_ASC_M 5

// config b fields
`define SPC_B_SINGLE 7
`define SPC_B_SPARE 6
`define SPC_B_RDBUF 5
`define SPC_B_HOLD 2

// commit field
`define SPC_C_COMMIT 0

// reset values and fixed fields
`define SPC_RST_BYTE 8'h00
`define SPC_RST_BIT 1'b0
`define SPC_RSV_LOW_NIB 4'hf
`define SPC_ZERO_NIB 4'h0
`define SPC_RSV_PAIR 2'b00
`define SPC_RSV_SEVEN 7'h00
`define SPC_MSB_FORCED 1'b1

// pointer step and identity slices
`define SPC_ADDR_STEP 12'h001
`define SPC_SER_LO_RANGE 3:0
`define SPC_SER_HI_RANGE 11:4
`define SPC_VEND_LO_RANGE 7:0
`define SPC_VEND_HI_RANGE 15:8

// neutral identity values (arbitrary)
`define SPC_ID_CLASS 4'h9
`define SPC_ID_SERIAL 12'h3a7
`define SPC_ID_VARIANT 4'h2
`define SPC_ID_REV 4'h3
`define SPC_ID_IFVER 8'h00
`define SPC_ID_VENDOR 16'h1234

`endif

// file: rtl/spc_regs.v
/*
 serial port configuration register bank with transfer option outputs,
 soft reset pulses, buffered/active select and identification registers.
 assumes the serial protocol engine on ref_clk issues one-cycle write and
 read strobes with an address; read data and the stepped pointer are registered.
 active copies of other blocks' registers are loaded on the commit pulse.
*/
`timescale 1ns/1ns
`include "spc_defines.vh"

module spc_regs (
	input wire ref_clk,
	input wire rst,
	input wire i2c_mode,
	input wire wr_en,
	input wire rd_en,
	input wire [11:0] addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_data_ext,
	output wire [7:0] rd_data,
	output wire addr_step_up,
	output wire [11:0] addr_next,
	output wire msb_first,
	output wire stream_en,
	output wire read_buffered,
	output wire chip_reset,
	output wire map_reset,
	output wire commit_pulse
);

	// identity codes kept as parameters so that their bytes can be sliced
	localparam [11:0] SERIAL_CODE = `SPC_ID_SERIAL; // arbitrary value
	localparam [15:0] VENDOR_CODE = `SPC_ID_VENDOR; // arbitrary value

	// config a fields; each mirror pair shares one stored bit
	reg asc_q; // pointer direction, high steps up
	reg asc_d;
	reg msbf_q; // readback order, high sends msb first
	reg msbf_d;
	reg srst_q; // soft reset, lives for one cycle
	reg srst_d;
	// config b fields
	reg single_q; // single instruction, streaming off
	reg single_d;
	reg spare_q; // writable reserved bit, stored only
	reg spare_d;
	reg rdbuf_q; // read source select
	reg rdbuf_d;
	reg hold_q; // chip reset that keeps the map
	reg hold_d;
	// commit register
	reg commit_q; // commit bit, self-clearing
	reg commit_d;
	// registered data outputs
	reg [7:0] rd_data_q; // read byte, stands the cycle after the strobe
	reg [7:0] rd_data_d;
	reg [11:0] addr_next_q; // stepped pointer for the engine
	reg [11:0] addr_next_d;
	reg [7:0] rd_mux; // selected read byte
	// decode and read assembly
	wire map_clr; // map back to defaults
	wire wr_a; // write to config a
	wire wr_b; // write to config b
	wire wr_c; // write to commit register
	wire [7:0] cfg_a; // config a with mirrors
	wire [7:0] cfg_b; // config b with reserved zeros
	wire [7:0] cfg_c; // commit register with reserved zeros

	// soft reset also returns the map to defaults, one cycle after the write;
	// a write that lands in that cycle is lost, so the engine must leave a gap
	assign map_clr = rst | srst_q;

	// one write strobe per writable register; other offsets are ignored
	assign wr_a = wr_en && (addr == `SPC_ADDR_CFG_A);
	assign wr_b = wr_en && (addr == `SPC_ADDR_CFG_B);
	assign wr_c = wr_en && (addr == `SPC_ADDR_COMMIT);

	// direction: either the bit or its mirror sets it
	always @*
	begin
		asc_d = asc_q; // hold between writes
		if (wr_a)
		begin
			asc_d = wr_data[`SPC_A_ASC] | wr_data[`SPC_A_ASC_M];
		end
	end

	// direction register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			asc_q <= `SPC_RST_BIT; // descending after reset
		end
		else
		begin
			asc_q <= asc_d;
		end
	end

	// bit order: either the bit or its mirror sets it
	always @*
	begin
		msbf_d = msbf_q; // hold between writes
		if (wr_a)
		begin
			msbf_d = wr_data[`SPC_A_MSBF] | wr_data[`SPC_A_MSBF_M];
		end
	end

	// bit order register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			msbf_q <= `SPC_RST_BIT; // lsb first after reset
		end
		else
		begin
			msbf_q <= msbf_d;
		end
	end

	// soft reset: either bit sets it, and it clears itself next cycle
	always @*
	begin
		srst_d = `SPC_RST_BIT; // self-clearing
		if (wr_a)
		begin
			srst_d = wr_data[`SPC_A_RESET] | wr_data[`SPC_A_RESET_M];
		end
	end

	// soft reset register; map_clr clears it, so it cannot stick high
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			srst_q <= `SPC_RST_BIT;
		end
		else
		begin
			srst_q <= srst_d;
		end
	end

	// single instruction bit
	always @*
	begin
		single_d = single_q; // hold between writes
		if (wr_b)
		begin
			single_d = wr_data[`SPC_B_SINGLE];
		end
	end

	// single instruction register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			single_q <= `SPC_RST_BIT; // streaming allowed after reset
		end
		else
		begin
			single_q <= single_d;
		end
	end

	// reserved but writable bit, kept so that it reads back
	always @*
	begin
		spare_d = spare_q; // hold between writes
		if (wr_b)
		begin
			spare_d = wr_data[`SPC_B_SPARE];
		end
	end

	// reserved bit register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			spare_q <= `SPC_RST_BIT;
		end
		else
		begin
			spare_q <= spare_d;
		end
	end

	// read source bit
	always @*
	begin
		rdbuf_d = rdbuf_q; // hold between writes
		if (wr_b)
		begin
			rdbuf_d = wr_data[`SPC_B_RDBUF];
		end
	end

	// read source register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			rdbuf_q <= `SPC_RST_BIT; // active copy after reset
		end
		else
		begin
			rdbuf_q <= rdbuf_d;
		end
	end

	// hold bit: chip stays in reset while it is set
	always @*
	begin
		hold_d = hold_q; // hold between writes
		if (wr_b)
		begin
			hold_d = wr_data[`SPC_B_HOLD];
		end
	end

	// hold register; the port reset, a soft reset or a config b write with the bit low clears it
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			hold_q <= `SPC_RST_BIT;
		end
		else
		begin
			hold_q <= hold_d;
		end
	end

	// commit bit lasts one cycle; a new write in that cycle wins
	always @*
	begin
		commit_d = `SPC_RST_BIT; // self-clearing
		if (wr_c)
		begin
			commit_d = wr_data[`SPC_C_COMMIT];
		end
	end

	// commit register
	always @(posedge ref_clk)
	begin
		if (map_clr)
		begin
			commit_q <= `SPC_RST_BIT;
		end
		else
		begin
			commit_q <= commit_d;
		end
	end

	// read byte is registered so the port sees a flop, at one cycle of latency
	always @*
	begin
		rd_data_d = `SPC_RST_BYTE; // idle bus reads zero
		if (rd_en)
		begin
			rd_data_d = rd_mux;
		end
	end

	// read data register; the port reset or a cycle without rd_en clears it, a soft reset does not
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			rd_data_q <= `SPC_RST_BYTE;
		end
		else
		begin
			rd_data_q <= rd_data_d;
		end
	end

	// pointer steps up when the direction bit is set, down when clear
	always @*
	begin
		if (asc_q)
		begin
			addr_next_d = addr + `SPC_ADDR_STEP; // ascending
		end
		else
		begin
			addr_next_d = addr - `SPC_ADDR_STEP; // descending, wraps at zero
		end
	end

	// stepped pointer follows addr every cycle, so it needs no reset
	always @(posedge ref_clk)
	begin
		addr_next_q <= addr_next_d;
	end

	// mirrors read back the same stored bit; reserved bits other than the spare bit read zero
	assign cfg_a = {srst_q, msbf_q, asc_q, `SPC_RSV_PAIR, asc_q, msbf_q, srst_q};
	assign cfg_b = {single_q, spare_q, rdbuf_q, `SPC_RSV_PAIR, hold_q, `SPC_RSV_PAIR};
	// commit bit reads high during its own pulse cycle
	assign cfg_c = {`SPC_RSV_SEVEN, commit_q};

	// read multiplexer; identity bytes are constants, so writes cannot move them
	always @*
	begin
		case (addr)
			`SPC_ADDR_CFG_A: rd_mux = cfg_a;
			`SPC_ADDR_CFG_B: rd_mux = cfg_b;
			`SPC_ADDR_CLASS: rd_mux = {`SPC_ZERO_NIB, `SPC_ID_CLASS};
			`SPC_ADDR_SER_LO: rd_mux = {SERIAL_CODE[`SPC_SER_LO_RANGE], `SPC_RSV_LOW_NIB};
			`SPC_ADDR_SER_HI: rd_mux = SERIAL_CODE[`SPC_SER_HI_RANGE];
			`SPC_ADDR_SIREV: rd_mux = {`SPC_ID_VARIANT, `SPC_ID_REV};
			`SPC_ADDR_IFVER: rd_mux = `SPC_ID_IFVER;
			`SPC_ADDR_VEND_LO: rd_mux = VENDOR_CODE[`SPC_VEND_LO_RANGE];
			`SPC_ADDR_VEND_HI: rd_mux = VENDOR_CODE[`SPC_VEND_HI_RANGE];
			`SPC_ADDR_COMMIT: rd_mux = cfg_c;
			// other registers come from the block that owns them,
			// which picks its copy from read_buffered
			default: rd_mux = rd_data_ext;
		endcase
	end

	// outputs
	assign rd_data = rd_data_q;
	assign addr_step_up = asc_q;
	assign addr_next = addr_next_q;
	// bit order has no effect in i2c mode, which always sends msb first
	assign msb_first = i2c_mode ? `SPC_MSB_FORCED : msbf_q;
	// engine must demand a new instruction per byte when low
	assign stream_en = ~single_q;
	assign read_buffered = rdbuf_q;
	// soft reset pulses a full reset; hold keeps the chip in reset
	assign chip_reset = srst_q | hold_q;
	// map is reset only by the soft reset, never by the hold
	assign map_reset = srst_q;
	// active copies elsewhere load on this one-cycle pulse
	assign commit_pulse = commit_q;

endmodule

// file: bench/spc_regs_asserts.sv
/* port checker for spc_regs
 assumes a bind onto spc_regs, one clock */
`timescale 1ns/1ns
`include "spc_defines.vh"
module spc_regs_asserts(
	input wire ref_clk,
	input wire rst,
	input wire i2c_mode,
	input wire wr_en,
	input wire rd_en,
	input wire [11:0] addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_data_ext,
	input wire [7:0] rd_data,
	input wire addr_step_up,
	input wire [11:0] addr_next,
	input wire msb_first,
	input wire stream_en,
	input wire read_buffered,
	input wire chip_reset,
	input wire map_reset,
	input wire commit_pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// writes taken; one landing on a soft reset pulse is lost
	wire wa = wr_en && !map_reset && addr == `SPC_ADDR_CFG_A;
	wire wb = wr_en && !map_reset && addr == `SPC_ADDR_CFG_B;
	property p_up; wa |=> addr_step_up == ($past(wr_data[2]) | $past(wr_data[5])); endproperty
	a_up: assert property (p_up) else $error("direction");
	// stepped pointer is registered: it reflects last cycle's address
	property p_nx; addr_next == ($past(addr_step_up) ? $past(addr) + 12'h001 : $past(addr) - 12'h001); endproperty
	a_nx: assert property (p_nx) else $error("next address");
	property p_ms; i2c_mode |-> msb_first; endproperty
	a_ms: assert property (p_ms) else $error("bit order");
	property p_sr; wa && (wr_data[0] | wr_data[7]) |=> chip_reset && map_reset ##1 !map_reset; endproperty
	a_sr: assert property (p_sr) else $error("soft reset");
	property p_st; wb |=> stream_en == !$past(wr_data[7]) && read_buffered == $past(wr_data[5]); endproperty
	a_st: assert property (p_st) else $error("config b");
	property p_hd; wb && wr_data[2] |=> chip_reset; endproperty
	a_hd: assert property (p_hd) else $error("hold");
	property p_cm; wr_en && !map_reset && addr == `SPC_ADDR_COMMIT && wr_data[0] |=> commit_pulse ##1 !commit_pulse; endproperty
	a_cm: assert property (p_cm) else $error("commit");
	property p_cl; rd_en && addr == `SPC_ADDR_CLASS |=> rd_data == {4'h0, `SPC_ID_CLASS}; endproperty
	a_cl: assert property (p_cl) else $error("class");
	cover property (wa && wr_data[0]);
	cover property (commit_pulse);
	cover property (i2c_mode && wr_en);
endmodule
bind spc_regs spc_regs_asserts u_chk(
	.ref_clk(ref_clk),
	.rst(rst),
	.i2c_mode(i2c_mode),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.addr(addr),
	.wr_data(wr_data),
	.rd_data_ext(rd_data_ext),
	.rd_data(rd_data),
	.addr_step_up(addr_step_up),
	.addr_next(addr_next),
	.msb_first(msb_first),
	.stream_en(stream_en),
	.read_buffered(read_buffered),
	.chip_reset(chip_reset),
	.map_reset(map_reset),
	.commit_pulse(commit_pulse)
);

// file: bench/spc_host_model.sv
/* host side of the register port
 assumes read data stands one cycle after the read strobe */
`timescale 1ns/1ns
module spc_host_model(
	input wire ref_clk,
	input wire [7:0] rd_data,
	output reg wr_en,
	output reg rd_en,
	output reg [11:0] addr,
	output reg [7:0] wr_data
);
	initial {wr_en, rd_en, addr, wr_data} = 22'h0;
	// one instruction per byte, no streaming
	task wr(input [11:0] a, input [7:0] d);
		@(posedge ref_clk) #1 {wr_en, addr, wr_data} = {1'b1, a, d};
		@(posedge ref_clk) #1 {wr_en, wr_data} = {1'b0, ~d}; // released byte goes stale
	endtask
	// read data is registered: taken just after the edge that captures it
	task rd(input [11:0] a, output [7:0] d);
		@(posedge ref_clk) #1 {rd_en, addr} = {1'b1, a};
		@(posedge ref_clk) #1 d = rd_data;
		rd_en = 0;
	endtask
endmodule

// file: bench/spc_regs_tb_top.sv
/* top bench for spc_regs
 assumes host model and checker compiled first */
`timescale 1ns/1ns
`include "spc_defines.vh"
module spc_regs_tb_top;
	reg ref_clk = 0, rst = 1, i2c_mode = 0;
	reg [7:0] rd_data_ext = 8'h5a; // foreign byte
	wire wr_en, rd_en, addr_step_up, msb_first, stream_en, read_buffered, chip_reset, map_reset, commit_pulse;
	wire [11:0] addr, addr_next;
	wire [7:0] wr_data, rd_data;
	reg [7:0] v;
	integer fails = 0, total_checks = 0, i;
	localparam [11:0] SER = `SPC_ID_SERIAL;
	localparam [15:0] VEN = `SPC_ID_VENDOR;
	always #20 ref_clk = ~ref_clk;
	spc_regs i_dut(
		.ref_clk(ref_clk),
		.rst(rst),
		.i2c_mode(i2c_mode),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wr_data(wr_data),
		.rd_data_ext(rd_data_ext),
		.rd_data(rd_data),
		.addr_step_up(addr_step_up),
		.addr_next(addr_next),
		.msb_first(msb_first),
		.stream_en(stream_en),
		.read_buffered(read_buffered),
		.chip_reset(chip_reset),
		.map_reset(map_reset),
		.commit_pulse(commit_pulse)
	);
	spc_host_model i_host(
		.ref_clk(ref_clk),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wr_data(wr_data)
	);
	task chk(input [11:0] s, input [11:0] e);
		total_checks = total_checks + 1;
		if (s !== e)
		begin
			fails = fails + 1;
			$display("wrong value at %0t: %h, expected %h", $time, s, e);
		end
	endtask
	task rc(input [11:0] a, input [7:0] e);
		i_host.rd(a, v);
		chk(v, e);
	endtask
	// fixed identity bytes, reserved nibbles included
	function [7:0] idv(input [11:0] a);
		case (a)
			12'h003: idv = {4'h0, `SPC_ID_CLASS};
			12'h004: idv = {SER[3:0], `SPC_RSV_LOW_NIB};
			12'h005: idv = SER[11:4];
			12'h006: idv = {`SPC_ID_VARIANT, `SPC_ID_REV};
			12'h00b: idv = `SPC_ID_IFVER;
			12'h00c: idv = VEN[7:0];
			default: idv = VEN[15:8];
		endcase
	endfunction
	task t_ids;
		for (i = 3; i < 14; i = i + 1)
			if (i < 7 || i > 10)
			begin
				rc(i, idv(i));
				i_host.wr(i, 8'hff);
				rc(i, idv(i));
			end
	endtask
	task t_cfg;
		i_host.wr(0, 8'h20);
		chk(addr_step_up, 1);
		rc(0, 8'h24);
		chk(addr_next, 12'h001);
		i_host.wr(0, 8'h02);
		chk({addr_step_up, msb_first}, 1);
		rc(0, 8'h42);
		chk(addr_next, 12'hfff);
		i2c_mode = 1;
		i_host.wr(0, 8'h00);
		chk(msb_first, 1);
		i2c_mode = 0;
		#1 chk(msb_first, 0);
	endtask
	task t_b;
		i_host.wr(1, 8'ha4);
		chk({stream_en, read_buffered, chip_reset, map_reset}, 6);
		rc(1, 8'ha4);
		i_host.wr(1, 0);
		chk({stream_en, chip_reset}, 2);
	endtask
	task t_sr;
		i_host.wr(0, 8'ha5);
		chk({chip_reset, map_reset}, 3);
		@(posedge ref_clk) #1 chk({chip_reset, map_reset}, 0);
		rc(0, 0);
	endtask
	task t_cm;
		i_host.wr(12'h00f, 1);
		chk(commit_pulse, 1);
		@(posedge ref_clk) #1 chk(commit_pulse, 0);
		rc(12'h00f, 0);
		rc(12'h7ff, 8'h5a);
	endtask
	task conclude;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk);
		#1 rst = 0;
		t_ids;
		t_cfg;
		t_b;
		t_sr;
		t_cm;
		conclude;
	end
	// hang guard, about thirteen times the run
	initial
	begin
		#40000 fails = fails + 1;
		conclude;
	end
endmodule
